// [logic/bpr_pkg.sv]
package bpr_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int          BPR_DATA_W       = 8;
  localparam int          BPR_ADDR_W       = 8;
  localparam int          BPR_NUM_REGS     = 3;
  localparam logic [7:0]  BPR_ADDR_BIAS    = 8'h47;
  localparam logic [7:0]  BPR_ADDR_PULLA   = 8'h48;
  localparam logic [7:0]  BPR_ADDR_PULLB   = 8'h49;
  localparam logic [7:0]  BPR_RST_BIAS     = 8'h00;
  localparam logic [7:0]  BPR_RST_PULLA    = 8'h7f;
  localparam logic [7:0]  BPR_RST_PULLB    = 8'h1f;
  localparam logic [7:0]  BPR_RDATA_IDLE   = 8'h00;

  // Register indices in the bank
  localparam int          BPR_IDX_BIAS     = 0;
  localparam int          BPR_IDX_PULLA    = 1;
  localparam int          BPR_IDX_PULLB    = 2;

  // ----------------------------------------
  // Field positions, analog bias register
  // ----------------------------------------
  localparam int          BPR_CBIAS_BIT    = 6;
  localparam int          BPR_AFE23_LSB    = 4;
  localparam int          BPR_MIC_LSB      = 2;
  localparam int          BPR_DAC_LSB      = 0;
  localparam int          BPR_LEVEL_W      = 2;

  // ----------------------------------------
  // Field positions, pull-up registers
  // ----------------------------------------
  localparam int          BPR_PU_DMIC23    = 6;
  localparam int          BPR_PU_DMIC01    = 5;
  localparam int          BPR_PU_FRAME     = 4;
  localparam int          BPR_PU_BITCLK    = 3;
  localparam int          BPR_PU_SOUT1     = 2;
  localparam int          BPR_PU_SOUT0     = 1;
  localparam int          BPR_PU_SIN       = 0;
  localparam int          BPR_PU_BOOT      = 4;
  localparam int          BPR_PU_CCLK      = 3;
  localparam int          BPR_PU_CDATA     = 2;
  localparam int          BPR_PU_ADDR1     = 1;
  localparam int          BPR_PU_ADDR0     = 0;

  // ----------------------------------------
  // Bias level codes
  // ----------------------------------------
  localparam logic [1:0]  BPR_LVL_00       = 2'h0;
  localparam logic [1:0]  BPR_LVL_01       = 2'h1;
  localparam logic [1:0]  BPR_LVL_10       = 2'h2;
  localparam logic [1:0]  BPR_LVL_11       = 2'h3;

  // One-hot grade positions
  localparam int          BPR_GRADE_W      = 5;
  localparam int          BPR_G_NORMAL     = 0;
  localparam int          BPR_G_XSAVE      = 1;
  localparam int          BPR_G_SAVE       = 2;
  localparam int          BPR_G_ENHANCED   = 3;
  localparam int          BPR_G_SUPERIOR   = 4;
  localparam logic [4:0]  BPR_GRADE_RST    = 5'h01;

  typedef logic [BPR_GRADE_W-1:0] bpr_grade_t;

endpackage

// [logic/bpr_cfg_reg.sv]
`timescale 1ns/10ps
module bpr_cfg_reg #(
  parameter int         WIDTH     = 8,
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  input  wire logic             core_clk,
  input  wire logic             rstn,
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wdata,
  output logic      [WIDTH-1:0] value_q
);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      value_q <= RESET_VAL[WIDTH-1:0];
    end else if (wr_en) begin
      value_q <= wdata;
    end
  end

endmodule

// [logic/bpr_bias_decode.sv]
`timescale 1ns/10ps
module bpr_bias_decode
  import bpr_pkg::*;
#(
  parameter bit CONVERTER_MAP = 1'b0
) (
  input  wire logic                       core_clk,
  input  wire logic                       rstn,
  input  wire logic [bpr_pkg::BPR_LEVEL_W-1:0] level,
  output bpr_pkg::bpr_grade_t             grade_q
);

  // ----------------------------------------
  // Code to grade
  // ----------------------------------------
  function automatic bpr_grade_t to_grade(input logic [1:0] code, input bit conv);
    bpr_grade_t g;
    g = '0;
    case (code)
      BPR_LVL_00: g[BPR_G_NORMAL] = 1'b1;
      BPR_LVL_01: g[conv ? BPR_G_SAVE : BPR_G_XSAVE] = 1'b1;
      BPR_LVL_10: g[conv ? BPR_G_SUPERIOR : BPR_G_ENHANCED] = 1'b1;
      default:    g[conv ? BPR_G_ENHANCED : BPR_G_SAVE] = 1'b1;
    endcase
    return g;
  endfunction

  wire bpr_grade_t grade_d = to_grade(level, CONVERTER_MAP);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      grade_q <= BPR_GRADE_RST;
    end else begin
      grade_q <= grade_d;
    end
  end

endmodule

// [logic/bpr_bias_pullup_regs.sv]
// How it works
// - Analog bias register at 0x47, resets to 0x00, all fields read and write.
// - Bias bit 6 high powers the central analog bias down, low keeps it up.
// - Bias bits 5:4 pick front-end 2/3 level: normal, extreme save, enhanced, save.
// - Bias bits 3:2 pick microphone level: normal, extreme save, enhanced, save.
// - Bias bits 1:0 pick converter level: normal, save, superior, enhanced.
// - First pull-up register at 0x48, resets to 0x7f, bit 7 reserved zero; the code stores and reads back bit 7 as written.
// - Pull-up bits are inverted: one disables the pull-up; all reset disabled.
// - First pull-up bits 6..0: mic 2/3, mic 0/1, frame, bit clock, out1, out0, in.
// - Second pull-up register at 0x49, resets to 0x1f, bits 7:5 reserved zero; the code stores and reads back bits 7:5 as written.
// - Second pull-up bits 4..0: boot select, bus clock, bus data, addr1, addr0.
`timescale 1ns/10ps
module bpr_bias_pullup_regs
  import bpr_pkg::*;
(
  input  wire logic                          core_clk,
  input  wire logic                          rstn,
  input  wire logic [bpr_pkg::BPR_ADDR_W-1:0] reg_addr,
  input  wire logic                          reg_wr_en,
  input  wire logic [bpr_pkg::BPR_DATA_W-1:0] reg_wdata,
  input  wire logic                          reg_rd_en,
  output logic      [bpr_pkg::BPR_DATA_W-1:0] reg_rdata,
  output logic                               reg_rd_valid,
  output logic                               reg_addr_hit,
  output logic                               central_bias_off,
  output logic      [bpr_pkg::BPR_LEVEL_W-1:0] front_end_23_bias_level,
  output logic      [bpr_pkg::BPR_LEVEL_W-1:0] microphone_bias_level,
  output logic      [bpr_pkg::BPR_LEVEL_W-1:0] converter_out_bias_level,
  output bpr_pkg::bpr_grade_t                front_end_23_grade,
  output bpr_pkg::bpr_grade_t                microphone_grade,
  output bpr_pkg::bpr_grade_t                converter_out_grade,
  output logic                               digital_mic_b_pullup_off,
  output logic                               digital_mic_a_pullup_off,
  output logic                               frame_clock_pullup_off,
  output logic                               bit_clock_pullup_off,
  output logic                               serial_out_b_pullup_off,
  output logic                               serial_out_a_pullup_off,
  output logic                               serial_in_pullup_off,
  output logic                               boot_select_pullup_off,
  output logic                               ctrl_clock_pin_pullup_off,
  output logic                               ctrl_data_pin_pullup_off,
  output logic                               addr_pin_b_pullup_off,
  output logic                               addr_pin_a_pullup_off
);

  import bpr_pkg::*;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  localparam logic [7:0] ADDR_TABLE [BPR_NUM_REGS] = '{BPR_ADDR_BIAS, BPR_ADDR_PULLA, BPR_ADDR_PULLB};
  localparam logic [7:0] RST_TABLE  [BPR_NUM_REGS] = '{BPR_RST_BIAS, BPR_RST_PULLA, BPR_RST_PULLB};

  function automatic logic [BPR_NUM_REGS-1:0] addr_select(input logic [BPR_ADDR_W-1:0] a);
    logic [BPR_NUM_REGS-1:0] s;
    s = '0;
    for (int i = 0; i < BPR_NUM_REGS; i++) begin
      s[i] = (a == ADDR_TABLE[i]);
    end
    return s;
  endfunction

  wire logic [BPR_NUM_REGS-1:0] sel     = addr_select(reg_addr);
  wire logic [BPR_NUM_REGS-1:0] wr_sel  = sel & {BPR_NUM_REGS{reg_wr_en}};
  wire logic                    rd_hit  = reg_rd_en & (|sel);

  assign reg_addr_hit = |sel;

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic [BPR_DATA_W-1:0] regs_q [BPR_NUM_REGS];

  for (genvar gi = 0; gi < BPR_NUM_REGS; gi++) begin : g_reg
    bpr_cfg_reg #(
      .WIDTH     (BPR_DATA_W),
      .RESET_VAL (RST_TABLE[gi])
    ) u_reg (
      .core_clk (core_clk),
      .rstn     (rstn),
      .wr_en    (wr_sel[gi]),
      .wdata    (reg_wdata),
      .value_q  (regs_q[gi])
    );
  end

  wire logic [BPR_DATA_W-1:0] bias_q  = regs_q[BPR_IDX_BIAS];
  wire logic [BPR_DATA_W-1:0] pulla_q = regs_q[BPR_IDX_PULLA];
  wire logic [BPR_DATA_W-1:0] pullb_q = regs_q[BPR_IDX_PULLB];

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  logic [BPR_DATA_W-1:0] rd_mux;

  always_comb begin
    rd_mux = BPR_RDATA_IDLE;
    for (int i = 0; i < BPR_NUM_REGS; i++) begin
      if (sel[i]) begin
        rd_mux = regs_q[i];
      end
    end
  end

  logic [BPR_DATA_W-1:0] rdata_q;
  logic                  rvalid_q;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q  <= BPR_RDATA_IDLE;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= rd_hit;
      if (rd_hit) begin
        rdata_q <= rd_mux;
      end
    end
  end

  assign reg_rdata    = rdata_q;
  assign reg_rd_valid = rvalid_q;

  // ----------------------------------------
  // Analog bias fields
  // ----------------------------------------
  assign central_bias_off         = bias_q[BPR_CBIAS_BIT];
  assign front_end_23_bias_level  = bias_q[BPR_AFE23_LSB +: BPR_LEVEL_W];
  assign microphone_bias_level    = bias_q[BPR_MIC_LSB +: BPR_LEVEL_W];
  assign converter_out_bias_level = bias_q[BPR_DAC_LSB +: BPR_LEVEL_W];

  bpr_bias_decode #(
    .CONVERTER_MAP (1'b0)
  ) u_dec_afe (
    .core_clk (core_clk),
    .rstn     (rstn),
    .level    (front_end_23_bias_level),
    .grade_q  (front_end_23_grade)
  );

  bpr_bias_decode #(
    .CONVERTER_MAP (1'b0)
  ) u_dec_mic (
    .core_clk (core_clk),
    .rstn     (rstn),
    .level    (microphone_bias_level),
    .grade_q  (microphone_grade)
  );

  bpr_bias_decode #(
    .CONVERTER_MAP (1'b1)
  ) u_dec_dac (
    .core_clk (core_clk),
    .rstn     (rstn),
    .level    (converter_out_bias_level),
    .grade_q  (converter_out_grade)
  );

  // ----------------------------------------
  // Pull-up disables, one means off
  // ----------------------------------------
  assign digital_mic_b_pullup_off  = pulla_q[BPR_PU_DMIC23];
  assign digital_mic_a_pullup_off  = pulla_q[BPR_PU_DMIC01];
  assign frame_clock_pullup_off    = pulla_q[BPR_PU_FRAME];
  assign bit_clock_pullup_off      = pulla_q[BPR_PU_BITCLK];
  assign serial_out_b_pullup_off   = pulla_q[BPR_PU_SOUT1];
  assign serial_out_a_pullup_off   = pulla_q[BPR_PU_SOUT0];
  assign serial_in_pullup_off      = pulla_q[BPR_PU_SIN];
  assign boot_select_pullup_off    = pullb_q[BPR_PU_BOOT];
  assign ctrl_clock_pin_pullup_off = pullb_q[BPR_PU_CCLK];
  assign ctrl_data_pin_pullup_off  = pullb_q[BPR_PU_CDATA];
  assign addr_pin_b_pullup_off     = pullb_q[BPR_PU_ADDR1];
  assign addr_pin_a_pullup_off     = pullb_q[BPR_PU_ADDR0];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  logic past_valid_q;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      past_valid_q <= 1'b0;
    end else begin
      past_valid_q <= 1'b1;
    end
  end

  a_bias_reset_value: assert property (!past_valid_q |-> bias_q == BPR_RST_BIAS)
    else $error("bias register not at reset value");

  a_bias_write_read: assert property (
    reg_wr_en && reg_addr == BPR_ADDR_BIAS ##1 reg_rd_en && reg_addr == BPR_ADDR_BIAS && !reg_wr_en
    |=> reg_rd_valid && reg_rdata == $past(reg_wdata, 2))
    else $error("bias register readback mismatch");

  a_central_bias_ctl: assert property (
    reg_wr_en && reg_addr == BPR_ADDR_BIAS |=> central_bias_off == $past(reg_wdata[BPR_CBIAS_BIT]))
    else $error("central bias control wrong");

  a_afe_grade_map: assert property (
    reg_wr_en && reg_addr == BPR_ADDR_BIAS && reg_wdata[BPR_AFE23_LSB +: BPR_LEVEL_W] == BPR_LVL_01
    ##1 !(reg_wr_en && reg_addr == BPR_ADDR_BIAS) |=> front_end_23_grade[BPR_G_XSAVE])
    else $error("front-end grade wrong");

  a_mic_grade_map: assert property (
    reg_wr_en && reg_addr == BPR_ADDR_BIAS && reg_wdata[BPR_MIC_LSB +: BPR_LEVEL_W] == BPR_LVL_10
    ##1 !(reg_wr_en && reg_addr == BPR_ADDR_BIAS) |=> microphone_grade[BPR_G_ENHANCED])
    else $error("microphone grade wrong");

  a_dac_grade_map: assert property (
    past_valid_q && $stable(converter_out_bias_level)
    && converter_out_bias_level == BPR_LVL_10 |-> converter_out_grade[BPR_G_SUPERIOR])
    else $error("converter grade wrong");

  a_pulla_reset_value: assert property (!past_valid_q |-> pulla_q == BPR_RST_PULLA)
    else $error("first pull-up register not at reset value");

  a_pullup_inverted: assert property (
    reg_wr_en && reg_addr == BPR_ADDR_PULLA && reg_wdata[BPR_PU_SIN] == 1'b0 |=> !serial_in_pullup_off)
    else $error("pull-up polarity wrong");

  a_pulla_bits_map: assert property (
    reg_wr_en && reg_addr == BPR_ADDR_PULLA
    |=> {digital_mic_b_pullup_off, frame_clock_pullup_off}
        == {$past(reg_wdata[BPR_PU_DMIC23]), $past(reg_wdata[BPR_PU_FRAME])})
    else $error("first pull-up bit map wrong");

  a_pullb_reset_value: assert property (!past_valid_q |-> pullb_q == BPR_RST_PULLB)
    else $error("second pull-up register not at reset value");

  a_pullb_bits_map: assert property (
    reg_wr_en && reg_addr == BPR_ADDR_PULLB
    |=> {boot_select_pullup_off, addr_pin_a_pullup_off}
        == {$past(reg_wdata[BPR_PU_BOOT]), $past(reg_wdata[BPR_PU_ADDR0])})
    else $error("second pull-up bit map wrong");

  a_other_addr_hold: assert property (
    reg_wr_en && !reg_addr_hit |=> $stable(bias_q) && $stable(pulla_q) && $stable(pullb_q))
    else $error("write to foreign address changed a register");

  a_read_miss_silent: assert property (reg_rd_en && !reg_addr_hit |=> !reg_rd_valid)
    else $error("read valid on unmapped address");

  // ----------------------------------------
  // Whole-register, read port and grade checks
  // ----------------------------------------

  a_bias_store_all: assert property (
    reg_wr_en && reg_addr == BPR_ADDR_BIAS |=> bias_q == $past(reg_wdata))
    else $error("bias register did not store the written byte");

  a_pulla_store_all: assert property (
    reg_wr_en && reg_addr == BPR_ADDR_PULLA |=> pulla_q == $past(reg_wdata))
    else $error("first pull-up register did not store the written byte");

  a_pullb_store_all: assert property (
    reg_wr_en && reg_addr == BPR_ADDR_PULLB |=> pullb_q == $past(reg_wdata))
    else $error("second pull-up register did not store the written byte");

  a_pulla_pins_all: assert property (
    reg_wr_en && reg_addr == BPR_ADDR_PULLA
    |=> {digital_mic_b_pullup_off, digital_mic_a_pullup_off, frame_clock_pullup_off, bit_clock_pullup_off,
         serial_out_b_pullup_off, serial_out_a_pullup_off, serial_in_pullup_off}
        == $past(reg_wdata[BPR_PU_DMIC23:BPR_PU_SIN]))
    else $error("first pull-up pin map wrong");

  a_pullb_pins_all: assert property (
    reg_wr_en && reg_addr == BPR_ADDR_PULLB
    |=> {boot_select_pullup_off, ctrl_clock_pin_pullup_off, ctrl_data_pin_pullup_off, addr_pin_b_pullup_off,
         addr_pin_a_pullup_off} == $past(reg_wdata[BPR_PU_BOOT:BPR_PU_ADDR0]))
    else $error("second pull-up pin map wrong");

  a_read_valid_hit: assert property (reg_rd_en && reg_addr_hit |=> reg_rd_valid)
    else $error("read of a mapped address gave no valid");

  a_read_pulla_data: assert property (
    reg_rd_en && reg_addr == BPR_ADDR_PULLA |=> reg_rdata == $past(pulla_q))
    else $error("first pull-up register read data wrong");

  a_read_pullb_data: assert property (
    reg_rd_en && reg_addr == BPR_ADDR_PULLB |=> reg_rdata == $past(pullb_q))
    else $error("second pull-up register read data wrong");

  a_rdata_hold: assert property (
    !(reg_rd_en && reg_addr_hit) |=> $stable(reg_rdata))
    else $error("read data changed without a mapped read");

  a_grade_onehot: assert property (
    $onehot(front_end_23_grade) && $onehot(microphone_grade) && $onehot(converter_out_grade))
    else $error("bias grade not one-hot");

  a_afe_grade_save: assert property (
    past_valid_q && $stable(front_end_23_bias_level) && front_end_23_bias_level == BPR_LVL_11
    |-> front_end_23_grade[BPR_G_SAVE])
    else $error("front-end saving grade wrong");

  a_dac_grade_save: assert property (
    past_valid_q && $stable(converter_out_bias_level) && converter_out_bias_level == BPR_LVL_01
    |-> converter_out_grade[BPR_G_SAVE])
    else $error("converter saving grade wrong");

  c_bias_write: cover property (reg_wr_en && reg_addr == BPR_ADDR_BIAS ##1 central_bias_off);
  c_pullup_enable: cover property (reg_wr_en && reg_addr == BPR_ADDR_PULLA ##1 !digital_mic_a_pullup_off);
  c_pullb_read: cover property (reg_rd_en && reg_addr == BPR_ADDR_PULLB ##1 reg_rd_valid);
  c_dac_superior: cover property (converter_out_grade[BPR_G_SUPERIOR]);
  c_fe_extreme_save: cover property (front_end_23_grade[BPR_G_XSAVE]);

endmodule

// [verif/bpr_bias_pullup_regs_test.sv]
`timescale 1ns/10ps
module bpr_bias_pullup_regs_test;
  import bpr_pkg::*;

  typedef struct {
    logic [7:0] a;
    logic [7:0] d;
    bpr_grade_t gf;
    bpr_grade_t gm;
    bpr_grade_t gc;
  } bpr_row_t;

  logic       core_clk;
  logic       rstn;
  logic [7:0] reg_addr;
  logic       reg_wr_en;
  logic [7:0] reg_wdata;
  logic       reg_rd_en;
  logic [7:0] reg_rdata;
  logic       reg_rd_valid;
  logic       reg_addr_hit;
  logic       cbias;
  logic [1:0] fe_lvl;
  logic [1:0] mic_lvl;
  logic [1:0] dac_lvl;
  bpr_grade_t fe_grade;
  bpr_grade_t mic_grade;
  bpr_grade_t dac_grade;
  logic [6:0] pua;
  logic [4:0] pub;
  int         mismatches;
  int         checks;

  // ----------------------------------------
  // Rows: address, data, grades (bias only)
  // ----------------------------------------
  bpr_row_t rows [8] = '{
    '{8'h47, 8'h40, 5'h01, 5'h01, 5'h01},
    '{8'h47, 8'h15, 5'h02, 5'h02, 5'h04},
    '{8'h47, 8'h2a, 5'h08, 5'h08, 5'h10},
    '{8'h47, 8'h3f, 5'h04, 5'h04, 5'h08},
    '{8'h48, 8'h00, 5'h00, 5'h00, 5'h00},
    '{8'h48, 8'h55, 5'h00, 5'h00, 5'h00},
    '{8'h49, 8'h0a, 5'h00, 5'h00, 5'h00},
    '{8'h49, 8'h1f, 5'h00, 5'h00, 5'h00}
  };

  bpr_bias_pullup_regs dut (
    .core_clk                  (core_clk),
    .rstn                      (rstn),
    .reg_addr                  (reg_addr),
    .reg_wr_en                 (reg_wr_en),
    .reg_wdata                 (reg_wdata),
    .reg_rd_en                 (reg_rd_en),
    .reg_rdata                 (reg_rdata),
    .reg_rd_valid              (reg_rd_valid),
    .reg_addr_hit              (reg_addr_hit),
    .central_bias_off          (cbias),
    .front_end_23_bias_level   (fe_lvl),
    .microphone_bias_level     (mic_lvl),
    .converter_out_bias_level  (dac_lvl),
    .front_end_23_grade        (fe_grade),
    .microphone_grade          (mic_grade),
    .converter_out_grade       (dac_grade),
    .digital_mic_b_pullup_off  (pua[6]),
    .digital_mic_a_pullup_off  (pua[5]),
    .frame_clock_pullup_off    (pua[4]),
    .bit_clock_pullup_off      (pua[3]),
    .serial_out_b_pullup_off   (pua[2]),
    .serial_out_a_pullup_off   (pua[1]),
    .serial_in_pullup_off      (pua[0]),
    .boot_select_pullup_off    (pub[4]),
    .ctrl_clock_pin_pullup_off (pub[3]),
    .ctrl_data_pin_pullup_off  (pub[2]),
    .addr_pin_b_pullup_off     (pub[1]),
    .addr_pin_a_pullup_off     (pub[0])
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] fields(input logic [7:0] a);
    case (a)
      8'h47: fields = {1'b0, cbias, fe_lvl, mic_lvl, dac_lvl};
      8'h48: fields = {1'b0, pua};
      default: fields = {3'h0, pub};
    endcase
  endfunction

  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_grade(input bpr_grade_t got, input bpr_grade_t exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t grade %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge core_clk);
    reg_wr_en = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic vld);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge core_clk);
    reg_rd_en = 1'b0;
    chk_val({7'h0, reg_rd_valid}, {7'h0, vld});
    chk_val(reg_rdata, exp);
  endtask

  task automatic tally_and_finish;
    if (mismatches == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  initial begin
    #(40 * 5000);
    mismatches++;
    tally_and_finish();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    mismatches = 0;
    checks = 0;
    rstn = 1'b0;
    reg_addr = 8'h00;
    reg_wr_en = 1'b0;
    reg_wdata = 8'h00;
    reg_rd_en = 1'b0;
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    rstn = 1'b1;
    chk_val(fields(8'h47), 8'h00);
    chk_val(fields(8'h48), 8'h7f);
    chk_val(fields(8'h49), 8'h1f);
    chk_grade(fe_grade, 5'h01);
    chk_grade(mic_grade, 5'h01);
    chk_grade(dac_grade, 5'h01);
    chk_val({7'h0, reg_rd_valid}, 8'h00);
    chk_val(reg_rdata, 8'h00);
    rd(8'h47, 8'h00, 1'b1);
    rd(8'h48, 8'h7f, 1'b1);
    rd(8'h49, 8'h1f, 1'b1);
    @(negedge core_clk);
    chk_val({7'h0, reg_rd_valid}, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(rows[i].a, rows[i].d);
      chk_val(fields(rows[i].a), rows[i].d);
      rd(rows[i].a, rows[i].d, 1'b1);
      if (rows[i].a == 8'h47) begin
        chk_grade(fe_grade, rows[i].gf);
        chk_grade(mic_grade, rows[i].gm);
        chk_grade(dac_grade, rows[i].gc);
      end
    end
    // Other registers untouched by later writes
    chk_val(fields(8'h47), 8'h3f);
    chk_val(fields(8'h48), 8'h55);
    // Unmapped neighbours: no effect, no valid, read data kept
    wr(8'h4a, 8'h00);
    wr(8'h46, 8'h00);
    rd(8'h4a, 8'h1f, 1'b0);
    rd(8'h46, 8'h1f, 1'b0);
    chk_val(fields(8'h49), 8'h1f);
    chk_val(fields(8'h47), 8'h3f);
    for (int a = 8'h45; a <= 8'h4b; a++) begin
      @(negedge core_clk);
      reg_addr = 8'(a);
      #1;
      chk_val({7'h0, reg_addr_hit}, {7'h0, (a >= 8'h47 && a <= 8'h49)});
    end
    // Same-cycle write and read returns old value
    @(negedge core_clk);
    reg_addr = 8'h47;
    reg_wdata = 8'h11;
    reg_wr_en = 1'b1;
    reg_rd_en = 1'b1;
    @(negedge core_clk);
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    chk_val(reg_rdata, 8'h3f);
    rd(8'h47, 8'h11, 1'b1);
    // Write then read on the very next edge
    @(negedge core_clk);
    reg_wdata = 8'h2a;
    reg_wr_en = 1'b1;
    @(negedge core_clk);
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b1;
    @(negedge core_clk);
    reg_rd_en = 1'b0;
    chk_val({7'h0, reg_rd_valid}, 8'h01);
    chk_val(reg_rdata, 8'h2a);
    chk_grade(dac_grade, 5'h10);
    // Mid-run reset takes effect at once
    @(negedge core_clk);
    rstn = 1'b0;
    #1;
    chk_val(fields(8'h48), 8'h7f);
    chk_val(fields(8'h47), 8'h00);
    chk_val(reg_rdata, 8'h00);
    chk_grade(dac_grade, 5'h01);
    repeat (2) @(negedge core_clk);
    rstn = 1'b1;
    rd(8'h49, 8'h1f, 1'b1);
    rd(8'h48, 8'h7f, 1'b1);
    tally_and_finish();
  end
endmodule
